// ### core/dual_reload_down_timer.sv
// two 8-bit reload down timers, chainable, with event input,
// toggle output and interrupt flags.
// assumes async oscillator and event pins
// and a 4-bit register port on one clock.
//
// What this block does
// - select 0 takes slow clock, 1 fast
// - event mode ignores timer 0 source and ratio
// - ratio 11/10/01/00 divides by 256/32/4/1
// - mode bit 1 counts events, 0 clocks
// - width bit 1 chains timers to 16 bits
// - chained: clock in timer 0, irq from timer 1
// - filter accepts change at second sample edge
// - filter off counts pin edges directly
// - polarity 0 falling, 1 rising, event mode only
// - count down from 8-bit reload
// - reload on preset and underflow
// - low nibble read latches high nibble
// - count readouts ignore writes
// - preset keeps run state, reads 0
// - run 1 starts, 0 stops and holds
// - source bit picks timer; chained forces 1
// - enable 1 drives toggle on pin, 0 high
// - own mask bit per timer, 1 enables
// - underflow sets flag even if masked; chained timer 0 sets none
// - write 1 clears flag, 0 does nothing
// - reset zeroes controls, flags, reloads, counts
// - run/stop act on tick; stop decrements once
// - run reads 1 until really stopped
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps

module dual_reload_down_timer
    import dual_timer_pkg::*;
#(
    parameter int unsigned NOISE_TICK_CYCLES_P = NOISE_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] reg_addr,
    input wire logic [3:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [3:0] reg_rdata,
    input wire logic slow_osc_clock,
    input wire logic fast_osc_clock,
    input wire logic event_input_pin,
    output logic output_port_pin,
    output logic timer0_irq_request,
    output logic timer1_irq_request
);

    typedef struct packed {
        logic slow_meta;
        logic slow_sync;
        logic slow_prev;
        logic fast_meta;
        logic fast_sync;
        logic fast_prev;
        logic event_meta;
        logic event_sync;
        logic event_filt;
        logic event_prev;
        logic [1:0] filt_pend;
        logic [15:0] sample_cnt;
        logic event_count_mode;
        logic chained_wide_mode;
        logic noise_rejector_enable;
        logic event_edge_polarity;
        logic toggle_output_source;
        logic toggle_output_enable;
        logic [1:0] source_select;
        logic [1:0][1:0] ratio;
        logic [1:0] run_req;
        timer_state_e [1:0] run_state;
        logic [1:0][7:0] reload;
        logic [1:0][7:0] count;
        logic [1:0][7:0] prescale;
        logic [1:0][3:0] high_hold;
        logic [1:0] irq_enable;
        logic [1:0] irq_flag;
        logic [1:0] irq_request;
        logic toggle_level;
        logic pin;
        logic [3:0] rdata;
    } timer_regs_s;

    localparam timer_regs_s REGS_RESET = '{
        slow_meta: 1'b0,
        slow_sync: 1'b0,
        slow_prev: 1'b0,
        fast_meta: 1'b0,
        fast_sync: 1'b0,
        fast_prev: 1'b0,
        event_meta: 1'b0,
        event_sync: 1'b0,
        event_filt: 1'b0,
        event_prev: 1'b0,
        filt_pend: 2'h0,
        sample_cnt: 16'h0000,
        event_count_mode: 1'b0,
        chained_wide_mode: 1'b0,
        noise_rejector_enable: 1'b0,
        event_edge_polarity: 1'b0,
        toggle_output_source: 1'b0,
        toggle_output_enable: 1'b0,
        source_select: 2'h0,
        ratio: '0,
        run_req: 2'h0,
        run_state: {TIMER_STOPPED, TIMER_STOPPED},
        reload: {RESET_BYTE, RESET_BYTE},
        count: {RESET_BYTE, RESET_BYTE},
        prescale: '0,
        high_hold: {RESET_NIBBLE, RESET_NIBBLE},
        irq_enable: 2'h0,
        irq_flag: 2'h0,
        irq_request: 2'h0,
        toggle_level: 1'b0,
        pin: 1'b1,
        rdata: RESET_NIBBLE
    };

    localparam logic [15:0] SAMPLE_LAST = 16'(NOISE_TICK_CYCLES_P - 1);

    timer_regs_s st;
    timer_regs_s next_st;

    function automatic logic [7:0] ratio_mask(input logic [1:0] code);
        case (code)
            2'b00: ratio_mask = RATIO_MASK_DIV1;
            2'b01: ratio_mask = RATIO_MASK_DIV4;
            2'b10: ratio_mask = RATIO_MASK_DIV32;
            default: ratio_mask = RATIO_MASK_DIV256;
        endcase
    endfunction : ratio_mask

    always_comb begin
        logic slow_fall;
        logic fast_fall;
        logic src_tick;
        logic sample_tick;
        logic level;
        logic event_edge;
        logic [1:0] pre_tick;
        logic [1:0] in_tick;
        logic [1:0] uflow;
        logic toggle_hit;
        logic wr_sel;
        slow_fall = 1'b0;
        fast_fall = 1'b0;
        src_tick = 1'b0;
        sample_tick = 1'b0;
        level = 1'b0;
        event_edge = 1'b0;
        pre_tick = 2'b00;
        in_tick = 2'b00;
        uflow = 2'b00;
        toggle_hit = 1'b0;
        wr_sel = 1'b0;
        next_st = st;

        // first stages feed only the second stages
        next_st.slow_meta = slow_osc_clock;
        next_st.slow_sync = st.slow_meta;
        next_st.fast_meta = fast_osc_clock;
        next_st.fast_sync = st.fast_meta;
        next_st.event_meta = event_input_pin;
        next_st.event_sync = st.event_meta;
        next_st.slow_prev = st.slow_sync;
        next_st.fast_prev = st.fast_sync;
        slow_fall = st.slow_prev & ~st.slow_sync;
        fast_fall = st.fast_prev & ~st.fast_sync;

        // prescalers: free-running divide chains on the chosen source
        for (int i = 0; i < 2; i++) begin
            src_tick = st.source_select[i] ? fast_fall : slow_fall;
            if (src_tick) begin
                next_st.prescale[i] = st.prescale[i] + 8'h01;
            end
            pre_tick[i] = src_tick
                && ((st.prescale[i] & ratio_mask(st.ratio[i])) == ratio_mask(st.ratio[i]));
        end

        // internal sample signal for the noise rejector
        sample_tick = (st.sample_cnt == SAMPLE_LAST);
        next_st.sample_cnt = sample_tick ? 16'h0000 : st.sample_cnt + 16'h0001;
        // a change must survive two sample edges
        if (st.event_sync == st.event_filt) begin
            next_st.filt_pend = 2'h0;
        end else if (sample_tick) begin
            if (st.filt_pend == 2'h1) begin
                next_st.event_filt = st.event_sync;
                next_st.filt_pend = 2'h0;
            end else begin
                next_st.filt_pend = st.filt_pend + 2'h1;
            end
        end

        level = st.noise_rejector_enable ? st.event_filt : st.event_sync;
        next_st.event_prev = level;
        event_edge = st.event_edge_polarity ? (level & ~st.event_prev)
                                            : (~level & st.event_prev);

        // counters; timer 1 is evaluated after timer 0 so it can chain
        for (int i = 0; i < 2; i++) begin
            if (i == 0) begin
                in_tick[i] = st.event_count_mode ? event_edge : pre_tick[0];
            end else begin
                in_tick[i] = st.chained_wide_mode ? uflow[0] : pre_tick[1];
            end
            if (in_tick[i]) begin
                case (st.run_state[i])
                    TIMER_RUNNING: begin
                        // a stop request still lets this edge decrement
                        if (st.count[i] == 8'h00) begin
                            uflow[i] = 1'b1;
                            next_st.count[i] = st.reload[i];
                        end else begin
                            next_st.count[i] = st.count[i] - 8'h01;
                        end
                    end
                    TIMER_STOPPED: begin
                        next_st.count[i] = st.count[i];
                    end
                    default: begin
                        next_st.count[i] = st.count[i];
                    end
                endcase
                next_st.run_state[i] = st.run_req[i] ? TIMER_RUNNING : TIMER_STOPPED;
            end
        end

        // toggle output
        wr_sel = st.chained_wide_mode | st.toggle_output_source;
        toggle_hit = wr_sel ? uflow[1] : uflow[0];
        if (toggle_hit) begin
            next_st.toggle_level = ~st.toggle_level;
        end
        // pin is registered with the new toggle level, so it cannot glitch on a flip
        next_st.pin = st.toggle_output_enable ? next_st.toggle_level : 1'b1;

        // register writes
        if (reg_write) begin
            case (reg_addr)
                ADDR_TIMER0_MODE_CONTROL: begin
                    next_st.event_edge_polarity = reg_wdata[BIT_EVENT_EDGE_POLARITY];
                    next_st.noise_rejector_enable = reg_wdata[BIT_NOISE_REJECTOR_ENABLE];
                    next_st.event_count_mode = reg_wdata[BIT_EVENT_COUNT_MODE];
                    next_st.chained_wide_mode = reg_wdata[BIT_CHAINED_WIDE_MODE];
                end
                ADDR_CLOCK_SOURCE_AND_OUTPUT_CONTROL: begin
                    next_st.source_select[0] = reg_wdata[BIT_PRESCALER0_SOURCE_SELECT];
                    next_st.source_select[1] = reg_wdata[BIT_PRESCALER1_SOURCE_SELECT];
                    next_st.toggle_output_enable = reg_wdata[BIT_TOGGLE_OUTPUT_ENABLE];
                    next_st.toggle_output_source = reg_wdata[BIT_TOGGLE_OUTPUT_SOURCE];
                end
                ADDR_TIMER0_RUN_RELOAD_PRESCALE, ADDR_TIMER1_RUN_RELOAD_PRESCALE: begin
                    for (int i = 0; i < 2; i++) begin
                        if (reg_addr[0] == i[0]) begin
                            next_st.run_req[i] = reg_wdata[BIT_RUN];
                            next_st.ratio[i] = reg_wdata[BIT_RATIO_LSB +: 2];
                            if (reg_wdata[BIT_PRESET]) begin
                                next_st.count[i] = st.reload[i];
                            end
                        end
                    end
                end
                ADDR_TIMER0_RELOAD_LOW: begin
                    next_st.reload[0][3:0] = reg_wdata;
                end
                ADDR_TIMER0_RELOAD_HIGH: begin
                    next_st.reload[0][7:4] = reg_wdata;
                end
                ADDR_TIMER1_RELOAD_LOW: begin
                    next_st.reload[1][3:0] = reg_wdata;
                end
                ADDR_TIMER1_RELOAD_HIGH: begin
                    next_st.reload[1][7:4] = reg_wdata;
                end
                ADDR_TIMER_INTERRUPT_ENABLE: begin
                    next_st.irq_enable = reg_wdata[1:0];
                end
                ADDR_TIMER_INTERRUPT_FLAGS: begin
                    next_st.irq_flag = st.irq_flag & ~reg_wdata[1:0];
                end
                default: begin
                    // count readouts and unmapped addresses ignore writes
                    next_st.irq_flag = st.irq_flag;
                end
            endcase
        end

        // set after clear: a same-cycle underflow wins
        if (uflow[0] && !st.chained_wide_mode) begin
            next_st.irq_flag[0] = 1'b1;
        end
        if (uflow[1]) begin
            next_st.irq_flag[1] = 1'b1;
        end
        next_st.irq_request = next_st.irq_flag & next_st.irq_enable;

        // register reads: data valid in the cycle after the strobe only
        next_st.rdata = RESET_NIBBLE;
        if (reg_read) begin
            case (reg_addr)
                ADDR_TIMER0_MODE_CONTROL: begin
                    next_st.rdata = {st.chained_wide_mode, st.event_count_mode,
                                     st.noise_rejector_enable, st.event_edge_polarity};
                end
                ADDR_CLOCK_SOURCE_AND_OUTPUT_CONTROL: begin
                    next_st.rdata = {st.toggle_output_source, st.toggle_output_enable,
                                     st.source_select[1], st.source_select[0]};
                end
                ADDR_TIMER0_RUN_RELOAD_PRESCALE: begin
                    next_st.rdata = {st.ratio[0], 1'b0,
                                     st.run_req[0] | (st.run_state[0] == TIMER_RUNNING)};
                end
                ADDR_TIMER1_RUN_RELOAD_PRESCALE: begin
                    next_st.rdata = {st.ratio[1], 1'b0,
                                     st.run_req[1] | (st.run_state[1] == TIMER_RUNNING)};
                end
                ADDR_TIMER0_RELOAD_LOW: begin
                    next_st.rdata = st.reload[0][3:0];
                end
                ADDR_TIMER0_RELOAD_HIGH: begin
                    next_st.rdata = st.reload[0][7:4];
                end
                ADDR_TIMER1_RELOAD_LOW: begin
                    next_st.rdata = st.reload[1][3:0];
                end
                ADDR_TIMER1_RELOAD_HIGH: begin
                    next_st.rdata = st.reload[1][7:4];
                end
                ADDR_TIMER0_COUNT_LOW: begin
                    next_st.rdata = st.count[0][3:0];
                    next_st.high_hold[0] = st.count[0][7:4];
                end
                ADDR_TIMER0_COUNT_HIGH: begin
                    next_st.rdata = st.high_hold[0];
                end
                ADDR_TIMER1_COUNT_LOW: begin
                    next_st.rdata = st.count[1][3:0];
                    next_st.high_hold[1] = st.count[1][7:4];
                end
                ADDR_TIMER1_COUNT_HIGH: begin
                    next_st.rdata = st.high_hold[1];
                end
                ADDR_TIMER_INTERRUPT_ENABLE: begin
                    next_st.rdata = {2'b00, st.irq_enable};
                end
                ADDR_TIMER_INTERRUPT_FLAGS: begin
                    next_st.rdata = {2'b00, st.irq_flag};
                end
                default: begin
                    next_st.rdata = RESET_NIBBLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st <= REGS_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign output_port_pin = st.pin;
    assign timer0_irq_request = st.irq_request[0];
    assign timer1_irq_request = st.irq_request[1];

endmodule : dual_reload_down_timer

// ### core/dual_timer_pkg.sv
// shared constants of the dual timer: register map, fields,
// reset values, prescaler masks, filter timing.
// assumes a 100 MHz system clock.
package dual_timer_pkg;

    localparam int unsigned CLK_HZ = 100_000_000;
    // noise rejector samples on falling edges of an internal 2,048 Hz signal
    localparam int unsigned NOISE_SAMPLE_HZ = 2048;
    localparam int unsigned NOISE_TICK_CYCLES = CLK_HZ / NOISE_SAMPLE_HZ;

    localparam logic [15:0] ADDR_TIMER0_MODE_CONTROL = 16'hFFC0;
    localparam logic [15:0] ADDR_CLOCK_SOURCE_AND_OUTPUT_CONTROL = 16'hFFC1;
    localparam logic [15:0] ADDR_TIMER0_RUN_RELOAD_PRESCALE = 16'hFFC2;
    localparam logic [15:0] ADDR_TIMER1_RUN_RELOAD_PRESCALE = 16'hFFC3;
    localparam logic [15:0] ADDR_TIMER0_RELOAD_LOW = 16'hFFC4;
    localparam logic [15:0] ADDR_TIMER0_RELOAD_HIGH = 16'hFFC5;
    localparam logic [15:0] ADDR_TIMER1_RELOAD_LOW = 16'hFFC6;
    localparam logic [15:0] ADDR_TIMER1_RELOAD_HIGH = 16'hFFC7;
    localparam logic [15:0] ADDR_TIMER0_COUNT_LOW = 16'hFFC8;
    localparam logic [15:0] ADDR_TIMER0_COUNT_HIGH = 16'hFFC9;
    localparam logic [15:0] ADDR_TIMER1_COUNT_LOW = 16'hFFCA;
    localparam logic [15:0] ADDR_TIMER1_COUNT_HIGH = 16'hFFCB;
    localparam logic [15:0] ADDR_TIMER_INTERRUPT_ENABLE = 16'hFFE2;
    localparam logic [15:0] ADDR_TIMER_INTERRUPT_FLAGS = 16'hFFF2;

    // mode control fields
    localparam int BIT_EVENT_EDGE_POLARITY = 0;
    localparam int BIT_NOISE_REJECTOR_ENABLE = 1;
    localparam int BIT_EVENT_COUNT_MODE = 2;
    localparam int BIT_CHAINED_WIDE_MODE = 3;
    // clock source and output control fields
    localparam int BIT_PRESCALER0_SOURCE_SELECT = 0;
    localparam int BIT_PRESCALER1_SOURCE_SELECT = 1;
    localparam int BIT_TOGGLE_OUTPUT_ENABLE = 2;
    localparam int BIT_TOGGLE_OUTPUT_SOURCE = 3;
    // run / reload / prescale fields
    localparam int BIT_RUN = 0;
    localparam int BIT_PRESET = 1;
    localparam int BIT_RATIO_LSB = 2;

    localparam logic [3:0] RESET_NIBBLE = 4'h0;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // prescaler wrap masks for ratio codes 00..11 (divide by 1, 4, 32, 256)
    localparam logic [7:0] RATIO_MASK_DIV1 = 8'h00;
    localparam logic [7:0] RATIO_MASK_DIV4 = 8'h03;
    localparam logic [7:0] RATIO_MASK_DIV32 = 8'h1F;
    localparam logic [7:0] RATIO_MASK_DIV256 = 8'hFF;

    typedef enum logic [1:0] {
        TIMER_STOPPED = 2'b01,
        TIMER_RUNNING = 2'b10
    } timer_state_e;

endpackage : dual_timer_pkg

// ### sim/dual_timer_checker.sv
// assertions on the dual timer's ports.
// assumes binding to the timer top.
`timescale 1ns/1ps
module dual_timer_checker
    import dual_timer_pkg::*;
#(
    parameter int unsigned NOISE_TICK_CYCLES_P = NOISE_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] reg_addr,
    input wire logic [3:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [3:0] reg_rdata,
    input wire logic output_port_pin,
    input wire logic timer0_irq_request,
    input wire logic timer1_irq_request
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    logic rd_flags;
    logic rd_mask;
    logic rd_ctl;
    logic wr_mask;
    logic wr_off;
    assign rd_flags = reg_read && reg_addr == ADDR_TIMER_INTERRUPT_FLAGS;
    assign rd_mask = reg_read && reg_addr == ADDR_TIMER_INTERRUPT_ENABLE;
    // both run/preset registers differ only in address bit 0
    assign rd_ctl = reg_read && reg_addr[15:1] == ADDR_TIMER0_RUN_RELOAD_PRESCALE[15:1];
    assign wr_mask = reg_write && reg_addr == ADDR_TIMER_INTERRUPT_ENABLE;
    assign wr_off = reg_write && reg_addr == ADDR_CLOCK_SOURCE_AND_OUTPUT_CONTROL
        && !reg_wdata[BIT_TOGGLE_OUTPUT_ENABLE];
    a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 4'h0)
        else $error("read data not zero outside a read answer");
    a_preset_zero: assert property (rd_ctl |=> !reg_rdata[BIT_PRESET])
        else $error("preset bit read as one");
    a_unused_zero: assert property (rd_flags || rd_mask |=> reg_rdata[3:2] == 2'h0)
        else $error("unused flag or mask bits read as one");
    a_reset_quiet: assert property (
        $rose(rst_b) |-> output_port_pin && !timer0_irq_request && !timer1_irq_request)
        else $error("outputs not at reset level after reset");
    a_pin_released: assert property (wr_off |-> ##2 output_port_pin [*3])
        else $error("pin not high with toggle output off");
    a_mask0_off: assert property (wr_mask && !reg_wdata[0] |-> ##2 !timer0_irq_request)
        else $error("timer 0 request while masked");
    a_mask1_off: assert property (wr_mask && !reg_wdata[1] |-> ##2 !timer1_irq_request)
        else $error("timer 1 request while masked");
    a_irq0_flag: assert property (rd_flags ##1 timer0_irq_request |-> reg_rdata[0])
        else $error("timer 0 request without its flag");
    a_irq1_flag: assert property (rd_flags ##1 timer1_irq_request |-> reg_rdata[1])
        else $error("timer 1 request without its flag");
    a_irq1_mask: assert property (rd_mask ##1 timer1_irq_request |-> reg_rdata[1])
        else $error("timer 1 request without its mask");
endmodule : dual_timer_checker

bind dual_reload_down_timer dual_timer_checker #(.NOISE_TICK_CYCLES_P(NOISE_TICK_CYCLES_P))
    dual_timer_checker_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .output_port_pin(output_port_pin),
    .timer0_irq_request(timer0_irq_request), .timer1_irq_request(timer1_irq_request));

// ### sim/event_pulse_source.sv
// event pulse source for the timer's event pin.
// assumes holds of three clocks or more.
`timescale 1ns/1ps
module event_pulse_source (
    input wire logic clk,
    output logic event_input_pin
);
    initial event_input_pin = 1'b0;
    // levels change after a rising edge and stand whole clocks;
    // the pin synchroniser needs three clocks to see one
    task automatic drive(input logic lvl, input int hold);
        @(posedge clk);
        event_input_pin <= lvl;
        repeat (hold) @(posedge clk);
    endtask : drive
endmodule : event_pulse_source

// ### sim/tb.sv
// self-checking bench for the dual timer.
// assumes the checker and event source are compiled too.
`timescale 1ns/1ps
module tb;
    import dual_timer_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [3:0] reg_wdata = 4'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [3:0] reg_rdata;
    logic slow_osc_clock = 1'b0;
    logic fast_osc_clock = 1'b0;
    logic event_input_pin;
    logic output_port_pin;
    logic timer0_irq_request;
    logic timer1_irq_request;
    int failures = 0;
    int n_tests = 0;
    int m_cnt = 0;
    int m_rel = 0;
    int m_uf = 0;
    bit m_run = 1'b0;
    bit m_req = 1'b0;
    int div[4] = '{1, 4, 32, 256};
    logic [15:0] addrs[15] = '{16'hFFC0, 16'hFFC1, 16'hFFC2, 16'hFFC3, 16'hFFC4, 16'hFFC5,
        16'hFFC6, 16'hFFC7, 16'hFFC8, 16'hFFC9, 16'hFFCA, 16'hFFCB, 16'hFFE2, 16'hFFF2, 16'hFF00};
    logic [7:0] v;
    logic [3:0] n;
    logic p0;
    time t0;
    time t1;

    always #5 clk = ~clk;
    // oscillator edges avoid rising clk edges, so spacing is exact
    always #20 fast_osc_clock = ~fast_osc_clock;
    always #100 slow_osc_clock = ~slow_osc_clock;

    dual_reload_down_timer #(.NOISE_TICK_CYCLES_P(8)) dual_reload_down_timer_i (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .slow_osc_clock(slow_osc_clock), .fast_osc_clock(fast_osc_clock),
        .event_input_pin(event_input_pin), .output_port_pin(output_port_pin),
        .timer0_irq_request(timer0_irq_request), .timer1_irq_request(timer1_irq_request));
    event_pulse_source event_pulse_source_i (.clk(clk), .event_input_pin(event_input_pin));

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string w);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, w, got, exp);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [3:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic rd8(input logic [15:0] a, output logic [7:0] b);
        rd(a, b[3:0]);
        rd(a + 16'h0001, b[7:4]);
    endtask : rd8
    task automatic set8(input logic [15:0] a, input logic [7:0] b);
        wr(a, b[3:0]);
        wr(a + 16'h0001, b[7:4]);
    endtask : set8
    task automatic m_tick();
        if (m_run) begin
            if (m_cnt == 0) begin
                m_cnt = m_rel;
                m_uf++;
            end else begin
                m_cnt--;
            end
        end
        m_run = m_req;
    endtask : m_tick
    task automatic pulse(input logic lvl, input int hold, input bit counts);
        event_pulse_source_i.drive(lvl, hold);
        if (counts) m_tick();
    endtask : pulse
    task automatic fall_pulse();
        pulse(1'b1, 8, 1'b0);
        pulse(1'b0, 8, 1'b1);
    endtask : fall_pulse
    task automatic cmp0(input string w);
        rd8(ADDR_TIMER0_COUNT_LOW, v);
        check(16'(v), 16'(m_cnt[7:0]), w);
    endtask : cmp0
    // let a stray mode-change edge pass before presetting
    task automatic mode0(input logic [3:0] m);
        wr(ADDR_TIMER0_MODE_CONTROL, m);
        repeat (4) @(posedge clk);
        wr(ADDR_TIMER0_RUN_RELOAD_PRESCALE, 4'hF);
        m_cnt = m_rel;
        m_req = 1'b1;
    endtask : mode0
    task automatic next_rise(output time t);
        int k;
        k = 0;
        wr(ADDR_TIMER_INTERRUPT_FLAGS, 4'h2);
        repeat (2) @(posedge clk);
        while (timer1_irq_request !== 1'b1 && k < 20000) begin
            @(posedge clk);
            #1 k++;
        end
        t = $time;
    endtask : next_rise
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    initial begin
        #600000;
        failures++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        void'($urandom(2));
        foreach (addrs[i]) begin
            rd(addrs[i], n);
            check(16'(n), 16'h0000, "reset value");
        end
        wr(ADDR_TIMER0_COUNT_LOW, 4'hF);
        wr(ADDR_TIMER1_COUNT_HIGH, 4'hA);
        rd8(ADDR_TIMER0_COUNT_LOW, v);
        check(16'(v), 16'h0000, "count write");
        rd8(ADDR_TIMER1_COUNT_LOW, v);
        check(16'(v), 16'h0000, "count write");
        $display("test reset done");
        m_rel = $urandom_range(200, 8);
        set8(ADDR_TIMER0_RELOAD_LOW, 8'(m_rel));
        wr(ADDR_CLOCK_SOURCE_AND_OUTPUT_CONTROL, 4'h5);
        mode0(4'h4);
        repeat ($urandom_range(6, 2)) fall_pulse();
        cmp0("event count");
        p0 = output_port_pin;
        while (m_uf == 0) fall_pulse();
        cmp0("reload");
        check(16'(output_port_pin), 16'(!p0), "toggle");
        rd(ADDR_TIMER_INTERRUPT_FLAGS, n);
        check(16'(n), 16'h0001, "flag set");
        check(16'(timer0_irq_request), 16'h0000, "masked");
        wr(ADDR_TIMER_INTERRUPT_ENABLE, 4'h1);
        repeat (3) @(posedge clk);
        check(16'(timer0_irq_request), 16'h0001, "request");
        wr(ADDR_TIMER_INTERRUPT_FLAGS, 4'h0);
        rd(ADDR_TIMER_INTERRUPT_FLAGS, n);
        check(16'(n), 16'h0001, "write 0");
        wr(ADDR_TIMER_INTERRUPT_FLAGS, 4'h1);
        rd(ADDR_TIMER_INTERRUPT_FLAGS, n);
        check(16'(n), 16'h0000, "write 1");
        $display("test event falling done");
        mode0(4'h5);
        for (int i = 0; i < 6; i++) begin
            pulse(i % 2 == 0, 8, i % 2 == 0);
            cmp0("rising");
        end
        mode0(4'h7);
        pulse(1'b1, 3, 1'b0);
        pulse(1'b0, 40, 1'b0);
        cmp0("short pulse");
        pulse(1'b1, 40, 1'b1);
        pulse(1'b0, 40, 1'b0);
        cmp0("long pulse");
        $display("test polarity and filter done");
        mode0(4'h4);
        wr(ADDR_TIMER0_RUN_RELOAD_PRESCALE, 4'h0);
        m_req = 1'b0;
        rd(ADDR_TIMER0_RUN_RELOAD_PRESCALE, n);
        check(16'(n), 16'h0001, "run pending");
        fall_pulse();
        rd(ADDR_TIMER0_RUN_RELOAD_PRESCALE, n);
        check(16'(n), 16'h0000, "stopped");
        fall_pulse();
        cmp0("held");
        wr(ADDR_TIMER0_RUN_RELOAD_PRESCALE, 4'h1);
        m_req = 1'b1;
        fall_pulse();
        fall_pulse();
        cmp0("resumed");
        $display("test run stop done");
        wr(ADDR_TIMER0_MODE_CONTROL, 4'h0);
        set8(ADDR_TIMER1_RELOAD_LOW, 8'h03);
        wr(ADDR_TIMER_INTERRUPT_ENABLE, 4'h2);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_CLOCK_SOURCE_AND_OUTPUT_CONTROL, {2'b00, i < 4, 1'b0});
            wr(ADDR_TIMER1_RUN_RELOAD_PRESCALE, {2'(i), 2'b11});
            next_rise(t0);
            next_rise(t0);
            next_rise(t1);
            check(16'((t1 - t0) / 10), 16'(4 * div[i % 4] * (i < 4 ? 4 : 20)), "rate");
        end
        $display("test prescaler done");
        wr(ADDR_TIMER0_MODE_CONTROL, 4'h8);
        set8(ADDR_TIMER0_RELOAD_LOW, 8'h01);
        set8(ADDR_TIMER1_RELOAD_LOW, 8'h01);
        wr(ADDR_CLOCK_SOURCE_AND_OUTPUT_CONTROL, 4'h5);
        wr(ADDR_TIMER_INTERRUPT_ENABLE, 4'h3);
        wr(ADDR_TIMER0_RUN_RELOAD_PRESCALE, 4'h3);
        wr(ADDR_TIMER1_RUN_RELOAD_PRESCALE, 4'h3);
        wr(ADDR_TIMER_INTERRUPT_FLAGS, 4'h1);
        next_rise(t0);
        next_rise(t0);
        p0 = output_port_pin;
        next_rise(t1);
        check(16'((t1 - t0) / 10), 16'h0010, "chained");
        check(16'(output_port_pin), 16'(!p0), "chained toggle");
        rd(ADDR_TIMER_INTERRUPT_FLAGS, n);
        check(16'(n), 16'h0002, "chained flags");
        rd(ADDR_TIMER_INTERRUPT_ENABLE, n);
        check(16'(n), 16'h0003, "masks");
        $display("test chained done");
        complete_run();
    end
endmodule : tb
